// ### verilog/reset_timeout_and_watchdog.v
// Reset time-out sequencer, reset-cause flags and watchdog control.
// Assumes all inputs are synchronous to CORE_CLK_I; the watchdog
// oscillator and main oscillator arrive as one-cycle tick strobes.
//
// Notes on behaviour
// RL1 - Power-on runs power-up delay if enabled, then 1024 oscillator cycles in crystal modes.
// RL2 - RC mode with power-up timer off leaves reset with no delay; a brown-out still runs the power-up delay.
// RL3 - Master clear held past all time-outs starts execution on release.
// RL4 - Crystal: 72 ms plus 1024 cycles, or 1024 alone; RC: 72 ms or none.
// RL5 - Reset-cause flags decode power-on, brown-out, watchdog reset or wake, clear.
// RL6 - Resets load PC 000h, wake-ups PC+1; status loads per reset kind.
// RL7 - Interrupt wake with global enable set loads vector 0004h.
// RL8 - Brown-out flag set by software, cleared by hardware on brown-out.
// RL9 - Power-on flag cleared by hardware only on power-on reset.
// RL10 - Watchdog counts on its own oscillator, also during sleep.
// RL11 - Watchdog timeout in normal operation resets the device.
// RL12 - Watchdog timeout in sleep wakes the device instead.
// RL13 - A watchdog timeout while running or in sleep clears the timeout flag.
// RL14 - Watchdog enable configuration bit low disables the watchdog.
// RL15 - Assigned prescaler multiplies the watchdog period by the chosen ratio.
// RL16 - Clear-watchdog and sleep clear counter and assigned prescaler.
// RL17 - Clear-watchdog zeros prescaler count but keeps its assignment.
// RL18 - Clear-watchdog zeros counter and sets timeout and powerdown flags.
// RL19 - Internal reset stays asserted until the last enabled stage ends.
`timescale 1ns/100ps
`include "reset_seq_regs.vh"

module reset_timeout_and_watchdog #(
  parameter POWER_UP_TIMER_CYCLES = `POWER_UP_TIMER_TIME_US * `CORE_CLK_MHZ,
  parameter OST_CYCLES  = `OST_OSC_CYCLES
) (
  input  wire                CORE_CLK_I,
  input  wire                RST_N_I,
  input  wire                CLK_EN_I,
  input  wire                MASTER_CLEAR_PIN_N_I,
  input  wire                BROWNOUT_I,
  input  wire                BROWNOUT_DETECT_ENABLE_I,
  input  wire                WATCHDOG_ENABLE_CFG_I,
  input  wire                POWER_UP_TIMER_ENABLE_N_I,
  input  wire [1:0]          OSC_MODE_I,
  input  wire                OSC_TICK_I,
  input  wire                WDOG_OSC_TICK_I,
  input  wire                SLEEP_INSTR_I,
  input  wire                CLEAR_DOG_INSTR_I,
  input  wire                IRQ_WAKE_I,
  input  wire                GLOBAL_IRQ_ENABLE_I,
  input  wire [`ADDR_W-1:0]  REG_ADDR_I,
  input  wire [7:0]          REG_WDATA_I,
  input  wire                REG_WR_I,
  input  wire                REG_RD_I,
  output wire [7:0]          REG_RDATA_O,
  output wire                CORE_RESET_O,
  output wire                SLEEPING_O,
  output wire                PC_LOAD_O,
  output wire [`PC_W-1:0]    PC_TARGET_O,
  output wire                PC_INCREMENT_O
);

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_POWER_UP_TIMER  = 3'h1;
  localparam [2:0] ST_OST   = 3'h2;
  localparam [2:0] ST_SLEEP = 3'h3;
  localparam [2:0] ST_WAKE  = 3'h4;
  // Wake only waits for the oscillator.

  // Cut to the counter width on purpose.
  localparam [31:0]           POWER_UP_TIMER_LAST_FULL = POWER_UP_TIMER_CYCLES - 1;
  localparam [31:0]           OST_LAST_FULL  = OST_CYCLES - 1;
  localparam [`SEQ_CNT_W-1:0] POWER_UP_TIMER_LAST = POWER_UP_TIMER_LAST_FULL[`SEQ_CNT_W-1:0];
  localparam [`SEQ_CNT_W-1:0] OST_LAST  = OST_LAST_FULL[`SEQ_CNT_W-1:0];
  localparam [`SEQ_CNT_W-1:0] CNT_ZERO  = {`SEQ_CNT_W{1'b0}};

  // Every other mode runs from a crystal.
  function crystal_mode;
    input [1:0] mode;
    begin
      crystal_mode = (mode != `OSC_RC_MODE);
    end
  endfunction

  reg [2:0]            state_reg;
  reg [2:0]            state_next;
  reg [`SEQ_CNT_W-1:0] cnt_reg;
  reg [`SEQ_CNT_W-1:0] cnt_next;
  reg                  por_pending_reg;
  reg                  master_clear_pin_low_prev_reg;
  reg                  wake_irq_reg;
  reg                  core_reset_reg;
  reg                  core_reset_next;
  reg                  pc_load_reg;
  reg [`PC_W-1:0]      pc_target_reg;
  reg                  pc_inc_reg;
  reg [7:0]            option_reg;
  reg [7:0]            status_reg;
  reg [1:0]            pwr_ctrl_reg;
  reg [7:0]            rdata_reg;
  reg [7:0]            rdata_next;

  wire crystal   = crystal_mode(OSC_MODE_I);
  wire master_clear_pin_low  = ~MASTER_CLEAR_PIN_N_I;
  wire wdog_to;
  wire sleeping  = (state_reg == ST_SLEEP) || (state_reg == ST_WAKE);

  // ------------------------------------------------------------
  // Reset and wake events
  // ------------------------------------------------------------
  // Brown-out is a level: while it stands the sequence restarts every
  // cycle, so the power-up delay only begins once supply recovers.
  // One event per cycle, by priority.
  wire ev_por      = por_pending_reg;
  wire ev_bor      = ~ev_por & BROWNOUT_I & BROWNOUT_DETECT_ENABLE_I;
  wire ev_master_clear_pin     = ~ev_por & ~ev_bor & master_clear_pin_low & ~master_clear_pin_low_prev_reg;
  wire ev_wdog_rst = ~ev_por & ~ev_bor & ~ev_master_clear_pin & wdog_to
                     & (state_reg == ST_RUN); // RL11
  wire quiet       = ~ev_por & ~ev_bor & ~ev_master_clear_pin;
  wire ev_wdog_wk  = quiet & wdog_to & (state_reg == ST_SLEEP); // RL12
  wire ev_irq_wk   = quiet & ~wdog_to & IRQ_WAKE_I
                     & (state_reg == ST_SLEEP);
  wire ev_sleep    = quiet & ~ev_wdog_rst & SLEEP_INSTR_I
                     & (state_reg == ST_RUN);
  wire start_req   = ev_por | ev_bor | ev_master_clear_pin | ev_wdog_rst;
  wire power_up_timer_need   = ev_bor | ~POWER_UP_TIMER_ENABLE_N_I; // RL4

  // ------------------------------------------------------------
  // Time-out sequence
  // ------------------------------------------------------------
  always @* begin
    // One counter serves the power-up, oscillator and wake counts.
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (start_req) begin
      cnt_next = CNT_ZERO;
      if (power_up_timer_need) begin
        state_next = ST_POWER_UP_TIMER; // RL1
      end else if (crystal) begin
        state_next = ST_OST; // RL4
      end else begin
        state_next = ST_RUN; // RL2
      end
    end else begin
      case (state_reg)
        ST_POWER_UP_TIMER: begin
          if (cnt_reg == POWER_UP_TIMER_LAST) begin
            cnt_next   = CNT_ZERO;
            state_next = crystal ? ST_OST : ST_RUN; // RL1
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        ST_OST, ST_WAKE: begin
          if (OSC_TICK_I) begin
            if (cnt_reg == OST_LAST) begin
              cnt_next   = CNT_ZERO;
              state_next = ST_RUN; // RL19
            end else begin
              cnt_next = cnt_reg + 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (ev_sleep) begin
            state_next = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (ev_wdog_wk || ev_irq_wk) begin
            cnt_next   = CNT_ZERO;
            state_next = crystal ? ST_WAKE : ST_RUN; // RL4
          end
        end
        default: begin
          state_next = ST_RUN;
        end
      endcase
    end
  end

  always @* begin
    // The pin term alone keeps reset up once time-outs have expired.
    // The request term holds reset one cycle
    // even when no time-out stage runs.
    core_reset_next = start_req || (state_next == ST_POWER_UP_TIMER)
                      || (state_next == ST_OST) || master_clear_pin_low; // RL19 RL3 RL11
  end

  // A wake continues at PC+1 unless an
  // enabled interrupt caused it; the cause is
  // latched for the crystal wake count.
  wire wake_done = sleeping && (state_next == ST_RUN) && !start_req;
  wire wake_irq  = (state_reg == ST_SLEEP) ? ev_irq_wk : wake_irq_reg;

  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg         <= ST_RUN;
      cnt_reg           <= {`SEQ_CNT_W{1'b0}};
      por_pending_reg   <= 1'b1;
      master_clear_pin_low_prev_reg <= 1'b0;
      wake_irq_reg      <= 1'b0;
      core_reset_reg    <= 1'b1;
      pc_load_reg       <= 1'b0;
      pc_target_reg     <= `PC_RESET_VECTOR;
      pc_inc_reg        <= 1'b0;
    end else if (CLK_EN_I) begin
      state_reg         <= state_next;
      cnt_reg           <= cnt_next;
      por_pending_reg   <= 1'b0;
      master_clear_pin_low_prev_reg <= master_clear_pin_low;
      core_reset_reg    <= core_reset_next;
      if (ev_wdog_wk || ev_irq_wk) begin
        wake_irq_reg <= ev_irq_wk;
      end
      // The load rises with the release.
      pc_load_reg <= 1'b0;
      if (core_reset_reg && !core_reset_next) begin
        pc_load_reg   <= 1'b1;
        pc_target_reg <= `PC_RESET_VECTOR; // RL6
        pc_inc_reg    <= 1'b0;
      end else if (wake_done && !core_reset_next) begin
        pc_load_reg <= 1'b1;
        if (wake_irq && GLOBAL_IRQ_ENABLE_I) begin
          pc_target_reg <= `PC_IRQ_VECTOR; // RL7
          pc_inc_reg    <= 1'b0;
        end else begin
          pc_target_reg <= `PC_RESET_VECTOR;
          pc_inc_reg    <= 1'b1; // RL6
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  // Held clear through reset stages so a fresh period starts on release.
  // A timeout while running resets, in sleep
  // wakes, and during the wake count is lost.
  wire wdog_clear = CLEAR_DOG_INSTR_I || ev_sleep || core_reset_reg; // RL16

  watchdog_timer #(
    .CNT_W (`WDOG_CNT_W),
    .PRE_W (`WDOG_PRE_W)
  ) u_watchdog (
    .clk_i     (CORE_CLK_I),
    .rst_n_i   (RST_N_I),
    .clk_en_i  (CLK_EN_I),
    .tick_i    (WDOG_OSC_TICK_I),
    .enable_i  (WATCHDOG_ENABLE_CFG_I), // RL14
    .use_pre_i (option_reg[`OPT_PRESCALER_ASSIGN]), // RL15
    .ratio_i   (option_reg[`OPT_PS_HI:`OPT_PS_LO]),
    .clear_i   (wdog_clear),
    .timeout_o (wdog_to)
  );

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Hardware updates follow the software write, so an event in the
  // same cycle as a write always wins. Timeout and powerdown flags are
  // read-only to software.
  // Master clear and watchdog keep power bits.
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      option_reg   <= `OPTION_RESET;
      status_reg   <= `STATUS_POR_VALUE;
      pwr_ctrl_reg <= 2'h0;
    end else if (CLK_EN_I) begin
      if (REG_WR_I) begin
        if (REG_ADDR_I == `ADDR_OPTION) begin
          option_reg <= REG_WDATA_I; // RL17
        end else if (REG_ADDR_I == `ADDR_STATUS) begin
          status_reg[`ST_HI_MSB:`ST_HI_LSB] <= REG_WDATA_I[`ST_HI_MSB:`ST_HI_LSB];
          status_reg[`ST_LO_MSB:`ST_LO_LSB] <= REG_WDATA_I[`ST_LO_MSB:`ST_LO_LSB];
        end else if (REG_ADDR_I == `ADDR_PWR_CTRL) begin
          pwr_ctrl_reg <= REG_WDATA_I[`PC_POR_N:`PC_BOR_N]; // RL8
        end
      end
      if (ev_por) begin
        status_reg <= `STATUS_POR_VALUE; // RL6
        pwr_ctrl_reg[`PC_POR_N] <= 1'b0; // RL9
      end else if (ev_bor) begin
        status_reg[`ST_HI_MSB:`ST_POWERDOWN_N] <= `ST_TOP_BROWNOUT; // RL5
        pwr_ctrl_reg[`PC_BOR_N] <= 1'b0; // RL8
      end else if (ev_master_clear_pin && sleeping) begin
        status_reg[`ST_HI_MSB:`ST_POWERDOWN_N] <= `ST_TOP_MASTER_CLEAR_PIN_SLEEP; // RL5
      end else if (ev_master_clear_pin) begin
        status_reg[`ST_HI_MSB:`ST_HI_LSB] <= `ST_HI_CLEARED;
      end else if (ev_wdog_rst) begin
        status_reg[`ST_HI_MSB:`ST_POWERDOWN_N] <= `ST_TOP_WDOG_RESET; // RL13
      end else if (ev_wdog_wk) begin
        status_reg[`ST_TIMEOUT_N]   <= 1'b0; // RL13
        status_reg[`ST_POWERDOWN_N] <= 1'b0;
      end else if (ev_irq_wk) begin
        status_reg[`ST_TIMEOUT_N]   <= 1'b1; // RL5
        status_reg[`ST_POWERDOWN_N] <= 1'b0;
      end else if (CLEAR_DOG_INSTR_I) begin
        status_reg[`ST_TIMEOUT_N]   <= 1'b1; // RL18
        status_reg[`ST_POWERDOWN_N] <= 1'b1;
      end else if (ev_sleep) begin
        status_reg[`ST_TIMEOUT_N]   <= 1'b1;
        status_reg[`ST_POWERDOWN_N] <= 1'b0;
      end
    end
  end

  // Read data stand one cycle, then zero,
  // so nothing stale lingers on the bus.
  always @* begin
    if (!REG_RD_I) begin
      rdata_next = `RDATA_NONE;
    end else if (REG_ADDR_I == `ADDR_OPTION) begin
      rdata_next = option_reg;
    end else if (REG_ADDR_I == `ADDR_STATUS) begin
      rdata_next = status_reg;
    end else if (REG_ADDR_I == `ADDR_PWR_CTRL) begin
      rdata_next = {6'h00, pwr_ctrl_reg};
    end else begin
      rdata_next = `RDATA_NONE;
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_reg <= `RDATA_NONE;
    end else if (CLK_EN_I) begin
      rdata_reg <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign REG_RDATA_O    = rdata_reg;
  assign CORE_RESET_O   = core_reset_reg;
  // Sleeping also covers the wake count.
  assign SLEEPING_O     = sleeping;
  assign PC_LOAD_O      = pc_load_reg;
  assign PC_TARGET_O    = pc_target_reg;
  assign PC_INCREMENT_O = pc_inc_reg;

endmodule

// ### verilog/reset_seq_regs.vh
// Constants for the reset time-out sequencer and watchdog block.
// Assumes inclusion by bare name from the design and bench files.
`ifndef RESET_SEQ_REGS_VH
`define RESET_SEQ_REGS_VH

// ------------------------------------------------------------
// Register offsets and reset values
// ------------------------------------------------------------
`define ADDR_W             8
`define ADDR_OPTION        8'h81
`define ADDR_STATUS        8'h90
`define ADDR_PWR_CTRL      8'h91
`define OPTION_RESET       8'hFF
`define STATUS_POR_VALUE   8'h18
`define RDATA_NONE         8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define OPT_PRESCALER_ASSIGN 3
`define OPT_PS_HI          2
`define OPT_PS_LO          0
`define ST_TIMEOUT_N       4
`define ST_POWERDOWN_N     3
`define ST_HI_MSB          7
`define ST_HI_LSB          5
`define ST_LO_MSB          2
`define ST_LO_LSB          0
`define PC_POR_N           1
`define PC_BOR_N           0

// Upper five status bits {hi[2:0], timeout_n, powerdown_n} per event.
`define ST_TOP_MASTER_CLEAR_PIN_SLEEP  5'h02
`define ST_TOP_WDOG_RESET  5'h01
`define ST_TOP_BROWNOUT    5'h03
`define ST_HI_CLEARED      3'h0

// ------------------------------------------------------------
// Program counter targets and oscillator modes
// ------------------------------------------------------------
`define PC_W               13
`define PC_RESET_VECTOR    13'h000
`define PC_IRQ_VECTOR      13'h004
`define OSC_RC_MODE        2'h3

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define POWER_UP_TIMER_TIME_US       72000
`define CORE_CLK_MHZ       125
`define OST_OSC_CYCLES     1024
`define SEQ_CNT_W          24
`define WDOG_CNT_W         8
`define WDOG_PRE_W         7

`endif

// ### verilog/watchdog_timer.v
// Watchdog counter with its optional prescaler.
// Assumes tick_i is a one-cycle strobe per watchdog oscillator period,
// already synchronous to the core clock.
`timescale 1ns/100ps

module watchdog_timer #(
  parameter CNT_W = 8,
  parameter PRE_W = 7
) (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       clk_en_i,
  input  wire       tick_i,
  input  wire       enable_i,
  input  wire       use_pre_i,
  input  wire [2:0] ratio_i,
  input  wire       clear_i,
  output wire       timeout_o
);

  reg [CNT_W-1:0] cnt_reg;
  reg [PRE_W-1:0] pre_reg;
  reg             timeout_reg;

  // Ratio 1:2^n, so the prescaler wraps after 2^n ticks.
  wire [PRE_W-1:0] pre_last = ~({PRE_W{1'b1}} << ratio_i);
  wire             pre_done = ~use_pre_i | (pre_reg == pre_last);

  // ------------------------------------------------------------
  // Counting
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg     <= {CNT_W{1'b0}};
      pre_reg     <= {PRE_W{1'b0}};
      timeout_reg <= 1'b0;
    end else if (clk_en_i) begin
      timeout_reg <= 1'b0;
      if (clear_i || !enable_i) begin
        cnt_reg <= {CNT_W{1'b0}}; // RL16 RL18
        pre_reg <= {PRE_W{1'b0}}; // RL17
      end else if (tick_i) begin // RL10
        if (pre_done) begin // RL15
          pre_reg     <= {PRE_W{1'b0}};
          cnt_reg     <= cnt_reg + 1'b1;
          timeout_reg <= &cnt_reg;
        end else begin
          pre_reg <= pre_reg + 1'b1;
        end
      end
    end
  end

  assign timeout_o = timeout_reg;

endmodule

// ### bench/reset_timeout_and_watchdog_assertions.sv
// Concurrent checks on the ports of the reset time-out and watchdog block.
// Assumes the block's header is on the include path; bound below the module.
`timescale 1ns/100ps
`include "reset_seq_regs.vh"

module reset_timeout_and_watchdog_assertions #(
  parameter POWER_UP_TIMER_CYCLES = 20,
  parameter OST_CYCLES  = 4
) (
  input wire             CORE_CLK_I,
  input wire             RST_N_I,
  input wire             CLK_EN_I,
  input wire             MASTER_CLEAR_PIN_N_I,
  input wire             BROWNOUT_I,
  input wire             BROWNOUT_DETECT_ENABLE_I,
  input wire             WATCHDOG_ENABLE_CFG_I,
  input wire             POWER_UP_TIMER_ENABLE_N_I,
  input wire [1:0]       OSC_MODE_I,
  input wire             SLEEP_INSTR_I,
  input wire             CLEAR_DOG_INSTR_I,
  input wire             IRQ_WAKE_I,
  input wire             GLOBAL_IRQ_ENABLE_I,
  input wire             CORE_RESET_O,
  input wire             SLEEPING_O,
  input wire             PC_LOAD_O,
  input wire [`PC_W-1:0] PC_TARGET_O,
  input wire             PC_INCREMENT_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // A frozen clock enable only lengthens this count, so the bound stays safe.
  reg [31:0] held_cnt;
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      held_cnt <= 32'h0;
    end else if (CORE_RESET_O) begin
      held_cnt <= held_cnt + 32'h1;
    end else begin
      held_cnt <= 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_master_clear_pin_hold;
    !MASTER_CLEAR_PIN_N_I && CLK_EN_I |=> CORE_RESET_O;
  endproperty
  a_master_clear_pin_hold: assert property (p_master_clear_pin_hold) else $error("reset not held by pin");

  property p_bo_hold;
    BROWNOUT_I && BROWNOUT_DETECT_ENABLE_I && CLK_EN_I |=> CORE_RESET_O;
  endproperty
  a_bo_hold: assert property (p_bo_hold) else $error("reset not held by brown-out");

  property p_rel_load;
    $fell(CORE_RESET_O) && CLK_EN_I |->
      PC_LOAD_O && PC_TARGET_O == 13'h000 && !PC_INCREMENT_O;
  endproperty
  a_rel_load: assert property (p_rel_load) else $error("no vector load after reset");

  property p_load_pulse;
    PC_LOAD_O |=> !PC_LOAD_O;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");

  property p_power_up_timer_min;
    $fell(CORE_RESET_O) && !POWER_UP_TIMER_ENABLE_N_I |-> held_cnt >= POWER_UP_TIMER_CYCLES;
  endproperty
  a_power_up_timer_min: assert property (p_power_up_timer_min) else $error("reset released early");

  property p_rc_fast;
    $rose(RST_N_I) && OSC_MODE_I == 2'h3 && POWER_UP_TIMER_ENABLE_N_I &&
      MASTER_CLEAR_PIN_N_I && !BROWNOUT_I && CLK_EN_I |-> ##[1:3] $fell(CORE_RESET_O);
  endproperty
  a_rc_fast: assert property (p_rc_fast) else $error("RC start delayed");

  property p_wake;
    SLEEPING_O && IRQ_WAKE_I && OSC_MODE_I == 2'h3 && MASTER_CLEAR_PIN_N_I &&
      !BROWNOUT_I && !WATCHDOG_ENABLE_CFG_I && CLK_EN_I |=> !SLEEPING_O &&
      (PC_LOAD_O && (GLOBAL_IRQ_ENABLE_I ?
        (PC_TARGET_O == 13'h004 && !PC_INCREMENT_O) : PC_INCREMENT_O));
  endproperty
  a_wake: assert property (p_wake) else $error("bad interrupt wake");

  property p_wd_off;
    (!WATCHDOG_ENABLE_CFG_I [*2]) ##0 (!CORE_RESET_O && !SLEEPING_O &&
      MASTER_CLEAR_PIN_N_I && !BROWNOUT_I) |=> !CORE_RESET_O;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("reset with watchdog off");

  property p_sleep_enter;
    SLEEP_INSTR_I && !CORE_RESET_O && !SLEEPING_O && !CLEAR_DOG_INSTR_I &&
      MASTER_CLEAR_PIN_N_I && !BROWNOUT_I && !WATCHDOG_ENABLE_CFG_I && CLK_EN_I
      |=> SLEEPING_O;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

  c_release: cover property ($fell(CORE_RESET_O));
  c_irq_vec: cover property (PC_LOAD_O && PC_TARGET_O == 13'h004);
  c_cont: cover property (PC_LOAD_O && PC_INCREMENT_O);
endmodule

bind reset_timeout_and_watchdog reset_timeout_and_watchdog_assertions #(
  .POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES),
  .OST_CYCLES(OST_CYCLES)
) chk_i (
  .CORE_CLK_I, .RST_N_I, .CLK_EN_I, .MASTER_CLEAR_PIN_N_I, .BROWNOUT_I,
  .BROWNOUT_DETECT_ENABLE_I, .WATCHDOG_ENABLE_CFG_I, .POWER_UP_TIMER_ENABLE_N_I,
  .OSC_MODE_I, .SLEEP_INSTR_I, .CLEAR_DOG_INSTR_I, .IRQ_WAKE_I, .GLOBAL_IRQ_ENABLE_I,
  .CORE_RESET_O, .SLEEPING_O, .PC_LOAD_O, .PC_TARGET_O, .PC_INCREMENT_O
);

// ### bench/tb_top.sv
// Self-checking bench for the reset time-out and watchdog block.
// Assumes the block's header is on the include path and short stage counts.
`timescale 1ns/100ps
`include "reset_seq_regs.vh"

module tb_top;
  localparam PW = 20;
  localparam OS = 4;
  reg              clk = 1'b0, rst_n = 1'b0, pin_n = 1'b1, bo = 1'b0, bde = 1'b0;
  reg              wd_en = 1'b0, pt_n = 1'b1, otick = 1'b0, wtick = 1'b0;
  reg              slp = 1'b0, cdg = 1'b0, irq = 1'b0, global_irq_enable = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [1:0]        mode = 2'h3;
  reg [7:0]        addr = 8'h00, wdat = 8'h00, st, pc, d;
  wire [7:0]       rdat;
  wire             core_rst, sleeping, pc_load, pc_inc;
  wire [`PC_W-1:0] pc_tgt;
  integer          errors = 0, compares = 0, loads = 0, n, i;
  integer          seed = 32'hBC1A4416;

  always #4 clk = ~clk;
  // The main oscillator runs at half the core rate.
  always @(posedge clk) otick <= ~otick;
  always @(posedge clk) if (pc_load === 1'b1) loads <= loads + 1;

  reset_timeout_and_watchdog #(.POWER_UP_TIMER_CYCLES(PW), .OST_CYCLES(OS)) reset_timeout_and_watchdog_i (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1), .MASTER_CLEAR_PIN_N_I(pin_n),
    .BROWNOUT_I(bo), .BROWNOUT_DETECT_ENABLE_I(bde), .WATCHDOG_ENABLE_CFG_I(wd_en),
    .POWER_UP_TIMER_ENABLE_N_I(pt_n), .OSC_MODE_I(mode), .OSC_TICK_I(otick),
    .WDOG_OSC_TICK_I(wtick), .SLEEP_INSTR_I(slp), .CLEAR_DOG_INSTR_I(cdg),
    .IRQ_WAKE_I(irq), .GLOBAL_IRQ_ENABLE_I(global_irq_enable), .REG_ADDR_I(addr), .REG_WDATA_I(wdat),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .CORE_RESET_O(core_rst),
    .SLEEPING_O(sleeping), .PC_LOAD_O(pc_load), .PC_TARGET_O(pc_tgt),
    .PC_INCREMENT_O(pc_inc));

  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  function integer dly(input [1:0] m, input p);
    dly = (p ? 0 : PW) + (m == 2'h3 ? 0 : 2 * OS);
  endfunction

  task cmp(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task tally_and_finish;
    begin
      if (errors == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task wreg(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdat <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  task rreg(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 cmp(rdat, e);
    end
  endtask

  task pulse(input s, input c);
    begin
      @(posedge clk);
      slp <= s;
      cdg <= c;
      @(posedge clk);
      slp <= 1'b0;
      cdg <= 1'b0;
      #1;
    end
  endtask

  task ticks(input integer k);
    repeat (k) begin
      @(posedge clk);
      wtick <= 1'b1;
      @(posedge clk);
      wtick <= 1'b0;
    end
  endtask

  // Waits for the next program counter load and checks where it goes.
  task wl(input [15:0] t, input c);
    begin
      n = 0;
      #1;
      while (pc_load !== 1'b1 && n < 300) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      cmp(pc_load, 1'b1);
      cmp(pc_inc, c);
      if (!c) cmp(pc_tgt, t);
    end
  endtask

  // Expects a watchdog event by k+2 ticks, and none after k-2 ticks.
  task dog(input integer k, input c);
    begin
      n = loads;
      ticks(k - 2);
      repeat (4) @(posedge clk);
      cmp(loads, n);
      ticks(4);
      repeat (4) @(posedge clk);
      cmp(loads, n + 1);
      cmp(pc_inc, c);
    end
  endtask

  task master_clear_pin;
    begin
      @(posedge clk);
      pin_n <= 1'b0;
      repeat (3) @(posedge clk);
      pin_n <= 1'b1;
      wl(16'h0, 1'b0);
    end
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    #400000;
    errors = errors + 1;
    tally_and_finish;
  end

  initial begin
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk);
      rst_n <= 1'b0;
      mode <= {2{i[1]}};
      pt_n <= i[0];
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      n = 0;
      @(posedge clk);
      #1;
      while (core_rst === 1'b1 && n < 200) begin
        n = n + 1;
        @(posedge clk);
        #1;
      end
      cmp(n >= dly(mode, pt_n) && n <= dly(mode, pt_n) + 4, 1'b1);
      rreg(8'h90, 8'h18);
      rreg(8'h91, 8'h00);
      rreg(8'h81, 8'hFF);
    end
    st = 8'h18;
    rreg(8'h55, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : $random(seed);
      wreg(8'h81, d);
      rreg(8'h81, d);
      wreg(8'h90, d);
      st = {d[7:5], st[4:3], d[2:0]};
      rreg(8'h90, st);
      wreg(8'h91, d);
      pc = {6'h0, d[1:0]};
      rreg(8'h91, pc);
      wreg(8'h55, d);
    end
    wreg(8'h91, 8'h03);
    pc = 8'h03;
    pulse(1'b0, 1'b1);
    st[4:3] = 2'b11;
    rreg(8'h90, st);
    wd_en <= 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      d = {4'h0, ~i[0], 3'h0} | ({$random(seed)} % 3);
      wreg(8'h81, d);
      pulse(1'b0, 1'b1);
      dog(d[3] ? (256 << d[2:0]) : 256, 1'b0);
      cmp(pc_tgt, 16'h0);
      st = {5'h01, st[2:0]};
      rreg(8'h90, st);
      rreg(8'h91, pc);
    end
    wreg(8'h81, 8'h09);
    pulse(1'b0, 1'b1);
    ticks(401);
    pulse(1'b0, 1'b1);
    n = loads;
    ticks(511);
    cmp(loads, n);
    rreg(8'h81, 8'h09);
    wreg(8'h81, 8'h00);
    pulse(1'b1, 1'b0);
    cmp(sleeping, 1'b1);
    st[4:3] = 2'b10;
    rreg(8'h90, st);
    dog(256, 1'b1);
    st[4:3] = 2'b00;
    rreg(8'h90, st);
    wd_en <= 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      global_irq_enable <= i[0];
      pulse(1'b1, 1'b0);
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      wl(16'h4, ~i[0]);
      st[4:3] = 2'b10;
      rreg(8'h90, st);
    end
    pulse(1'b1, 1'b0);
    master_clear_pin;
    st = {5'h02, st[2:0]};
    rreg(8'h90, st);
    wreg(8'h90, 8'hE5);
    st = {3'h7, st[4:3], 3'h5};
    master_clear_pin;
    st[7:5] = 3'h0;
    rreg(8'h90, st);
    @(posedge clk);
    bde <= 1'b1;
    bo <= 1'b1;
    repeat (2) @(posedge clk);
    bo <= 1'b0;
    wl(16'h0, 1'b0);
    st = {5'h03, st[2:0]};
    rreg(8'h90, st);
    rreg(8'h91, 8'h02);
    pulse(1'b0, 1'b1);
    n = loads;
    ticks(300);
    cmp(loads, n);
    tally_and_finish;
  end
endmodule
